/* rtl/dacc_pair.sv */
// Overview of operation
// RULE_01: two 72-bit accumulators, zero and one
// RULE_02: each accumulator presented as 96 bits
// RULE_03: reads of bits 95:72 return bit 71
// RULE_04: writes to bits 95:72 are discarded
// RULE_05: product instructions overwrite accumulator zero
// RULE_06: writes load guard, high or low slice
// RULE_07: reads return guard, high, middle, low slice
// RULE_08: selector picks accumulator; write touches slice only
`timescale 1ns/10ps
`default_nettype none
module dacc_pair (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_sel_i,
    input wire dacc_pkg::dacc_wr_t wr_cmd_i,
    input wire logic [31:0] wr_data_i,
    input wire logic rd_sel_i,
    input wire dacc_pkg::dacc_rd_t rd_cmd_i,
    input wire logic prod_we_i,
    input wire logic [71:0] prod_data_i,
    output logic [31:0] rd_data_o,
    output logic rd_valid_o,
    output logic [71:0] accumulator_zero_o,
    output logic [71:0] accumulator_one_o
);
    dacc_store_if sif ();

    // a command is taken at a rising edge and shows on the ports just after that
    // same edge; reads, writes and products may come back to back in any order
    // and nothing here ever stalls the core

    // read side registers
    logic [31:0] rd_data_q;
    logic [31:0] rd_data_d;
    logic rd_valid_q;
    logic rd_valid_d;
    // output copies of the stored pair
    logic [71:0] accumulator_zero_q;
    logic [71:0] accumulator_zero_d;
    logic [71:0] accumulator_one_q;
    logic [71:0] accumulator_one_d;
    // write path
    logic wr_hit;
    logic [71:0] cur_acc;
    logic [71:0] merged;
    // read path
    logic rd_hit;
    logic [71:0] rd_src;
    logic [95:0] view;

    ////////////////////////////////////////////////////////////////////////
    // storage for both accumulators; only 72 bits each are kept, the
    // upper 24 bits of the view never get a flop, and a write lands in
    // the store at the same edge that takes it
    dacc_store u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sif(sif)
    );

    ////////////////////////////////////////////////////////////////////////
    // present a stored value as the 96-bit view
    function automatic logic [95:0] widen(input logic [71:0] acc);
        widen = {{24{acc[dacc_pkg::SIGN_BIT]}}, acc}; // RULE_02 RULE_03
    endfunction

    // pick an accumulator by selector
    function automatic logic [71:0] pick(input logic sel,
        input logic [71:0] a0, input logic [71:0] a1);
        pick = (sel == dacc_pkg::SEL_ONE) ? a1 : a0; // RULE_08
    endfunction

    // one 32-bit window of the view, given its low bit; the middle
    // window overlaps its neighbours, the guard window does not
    function automatic logic [31:0] window(input logic [95:0] v,
        input int lsb);
        window = v[lsb +: dacc_pkg::SLICE_W];
    endfunction

    // the four read codes that return a slice; 5 to 7 are unused codes
    function automatic logic rd_legal(input dacc_pkg::dacc_rd_t cmd);
        rd_legal = (cmd == dacc_pkg::DACC_RD_GUARD)
            || (cmd == dacc_pkg::DACC_RD_HIGH)
            || (cmd == dacc_pkg::DACC_RD_MIDDLE)
            || (cmd == dacc_pkg::DACC_RD_LOW);
    endfunction

    // any slice write at all; the none code leaves both accumulators
    // alone
    function automatic logic wr_any(input dacc_pkg::dacc_wr_t cmd);
        wr_any = (cmd != dacc_pkg::DACC_WR_NONE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // slice write merge: the selected accumulator with one slice replaced,
    // every other stored bit carried over unchanged
    always_comb begin
        wr_hit = wr_any(wr_cmd_i);
        cur_acc = pick(wr_sel_i, sif.accumulator_zero, sif.accumulator_one);
        merged = cur_acc;
        unique case (wr_cmd_i)
            dacc_pkg::DACC_WR_NONE: begin
                merged = cur_acc;
            end
            dacc_pkg::DACC_WR_GUARD: begin
                // only bits 71:64 land; 95:72 have no storage, so a guard
                // read afterwards shows copies of bit 71, not what was
                // written above it
                merged[71:64] = wr_data_i[7:0]; // RULE_04 RULE_06
            end
            dacc_pkg::DACC_WR_HIGH: begin
                merged[dacc_pkg::HIGH_LSB +: dacc_pkg::SLICE_W] =
                    wr_data_i; // RULE_06
            end
            dacc_pkg::DACC_WR_LOW: begin
                merged[dacc_pkg::LOW_LSB +: dacc_pkg::SLICE_W] =
                    wr_data_i; // RULE_06
            end
        endcase
    end

    // write enables and data for the store. a product always wins
    // accumulator zero: the multiply result has nowhere else to go, so a
    // slice write to zero in that same cycle is lost
    always_comb begin
        sif.we0 = 1'b0;
        sif.we1 = 1'b0;
        sif.wdata0 = merged;
        sif.wdata1 = merged;
        // the selector steers a slice write to one accumulator only
        if (wr_hit) begin
            if (wr_sel_i == dacc_pkg::SEL_ONE) begin
                sif.we1 = 1'b1; // RULE_08
            end else begin
                sif.we0 = 1'b1; // RULE_08
            end
        end
        // products land whole; all 72 stored bits are replaced, and a
        // write to accumulator one in the same cycle still lands
        if (prod_we_i) begin
            sif.we0 = 1'b1; // RULE_05
            sif.wdata0 = prod_data_i; // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slice read mux; it looks at the stored values before this edge, so
    // a read in the cycle of a write returns the old contents
    always_comb begin
        rd_hit = rd_legal(rd_cmd_i);
        // the selector only steers the read; it never changes storage
        rd_src = pick(rd_sel_i, sif.accumulator_zero, sif.accumulator_one);
        view = widen(rd_src); // RULE_02
        rd_valid_d = rd_hit; // RULE_07
        rd_data_d = rd_data_q;
        unique case (rd_cmd_i)
            dacc_pkg::DACC_RD_NONE: begin
                // idle: hold the last slice for slow consumers
                rd_data_d = rd_data_q;
            end
            dacc_pkg::DACC_RD_GUARD: begin
                // upper 24 bits are copies of the sign bit
                rd_data_d = window(view, dacc_pkg::GUARD_LSB); // RULE_07
            end
            dacc_pkg::DACC_RD_HIGH: begin
                rd_data_d = window(view, dacc_pkg::HIGH_LSB); // RULE_07
            end
            dacc_pkg::DACC_RD_MIDDLE: begin
                // straddles the high and low write slices
                rd_data_d = window(view, dacc_pkg::MIDDLE_LSB); // RULE_07
            end
            dacc_pkg::DACC_RD_LOW: begin
                rd_data_d = window(view, dacc_pkg::LOW_LSB); // RULE_07
            end
            default: begin
                // unused codes read nothing and raise no valid
                rd_data_d = rd_data_q;
            end
        endcase
    end

    // read result registers; the data keeps its value between reads,
    // the valid flag stands for one cycle per legal read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_q <= dacc_pkg::RD_RESET;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output copies of both accumulators. they follow the store's write
    // port, so they always equal the stored values; keeping them in flops
    // here costs 144 bits but keeps the write mux out of the multiply
    // datapath's timing path
    always_comb begin
        accumulator_zero_d = sif.we0 ? sif.wdata0 : accumulator_zero_q;
        accumulator_one_d = sif.we1 ? sif.wdata1 : accumulator_one_q;
    end

    // copies reset with the store, to the same value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            accumulator_zero_q <= dacc_pkg::ACC_RESET; // RULE_01
            accumulator_one_q <= dacc_pkg::ACC_RESET; // RULE_01
        end else begin
            accumulator_zero_q <= accumulator_zero_d;
            accumulator_one_q <= accumulator_one_d;
        end
    end

    // ports come straight from the flops above
    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;
    assign accumulator_zero_o = accumulator_zero_q;
    assign accumulator_one_o = accumulator_one_q;
endmodule
`default_nettype wire

/* rtl/dacc_pkg.sv */
`default_nettype none
package dacc_pkg;
    // stored width and presented width of one accumulator
    localparam int STORE_W = 72;
    localparam int VIEW_W = 96;
    localparam int SLICE_W = 32;
    localparam int SIGN_BIT = 71;
    // slice low bit positions in the presented view
    localparam int GUARD_LSB = 64;
    localparam int HIGH_LSB = 32;
    localparam int MIDDLE_LSB = 16;
    localparam int LOW_LSB = 0;
    // accumulator reset value
    localparam logic [71:0] ACC_RESET = 72'h00_0000_0000_0000_0000;
    // read port reset value
    localparam logic [31:0] RD_RESET = 32'h0000_0000;
    // accumulator selector codes
    localparam logic SEL_ZERO = 1'b0;
    localparam logic SEL_ONE = 1'b1;

    // slice write commands
    typedef enum logic [1:0] {
        DACC_WR_NONE = 2'h0,
        DACC_WR_GUARD = 2'h1,
        DACC_WR_HIGH = 2'h2,
        DACC_WR_LOW = 2'h3
    } dacc_wr_t;

    // slice read commands
    typedef enum logic [2:0] {
        DACC_RD_NONE = 3'h0,
        DACC_RD_GUARD = 3'h1,
        DACC_RD_HIGH = 3'h2,
        DACC_RD_MIDDLE = 3'h3,
        DACC_RD_LOW = 3'h4
    } dacc_rd_t;
endpackage
`default_nettype wire

/* rtl/dacc_store.sv */
`timescale 1ns/10ps
`default_nettype none
module dacc_store (
    input wire logic clk_i,
    input wire logic rst_i,
    dacc_store_if.store sif
);
    logic [71:0] accumulator_zero_q;
    logic [71:0] accumulator_zero_d;
    logic [71:0] accumulator_one_q;
    logic [71:0] accumulator_one_d;

    // next value: load on write enable, otherwise hold
    always_comb begin
        accumulator_zero_d = sif.we0 ? sif.wdata0 : accumulator_zero_q;
        accumulator_one_d = sif.we1 ? sif.wdata1 : accumulator_one_q;
    end

    // only 72 bits are physically stored per accumulator
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            accumulator_zero_q <= dacc_pkg::ACC_RESET; // RULE_01
            accumulator_one_q <= dacc_pkg::ACC_RESET;
        end else begin
            accumulator_zero_q <= accumulator_zero_d;
            accumulator_one_q <= accumulator_one_d;
        end
    end

    assign sif.accumulator_zero = accumulator_zero_q;
    assign sif.accumulator_one = accumulator_one_q;
endmodule
`default_nettype wire

/* rtl/dacc_store_if.sv */
`timescale 1ns/10ps
`default_nettype none
// write port and stored contents of the accumulator pair
interface dacc_store_if;
    logic we0;
    logic we1;
    logic [71:0] wdata0;
    logic [71:0] wdata1;
    logic [71:0] accumulator_zero;
    logic [71:0] accumulator_one;
    modport ctrl (output we0, output we1, output wdata0, output wdata1,
        input accumulator_zero, input accumulator_one);
    modport store (input we0, input we1, input wdata0, input wdata1,
        output accumulator_zero, output accumulator_one);
endinterface
`default_nettype wire

/* testbench/dacc_mpy.sv */
`timescale 1ns/10ps
`default_nettype none
// multiply stand-in, result strobe in the cycle it is asked for
module dacc_mpy (
    input wire logic go_i,
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    output logic prod_we_o,
    output logic [71:0] prod_data_o
);
    // data keeps changing while no strobe is up
    assign prod_we_o = go_i;
    assign prod_data_o = {40'h0, a_i} * {40'h0, b_i};
endmodule
`default_nettype wire

/* testbench/dacc_pair_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module dacc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_sel_i,
    input wire dacc_pkg::dacc_wr_t wr_cmd_i,
    input wire logic [31:0] wr_data_i,
    input wire logic rd_sel_i,
    input wire dacc_pkg::dacc_rd_t rd_cmd_i,
    input wire logic prod_we_i,
    input wire logic [71:0] prod_data_i,
    input wire logic [31:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic [71:0] accumulator_zero_o,
    input wire logic [71:0] accumulator_one_o
);
    // read source before the read edge, so same-cycle writes stay unseen
    logic [71:0] ra;
    assign ra = rd_sel_i ? accumulator_one_o : accumulator_zero_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    rd_valid_a: assert property (rd_valid_o ==
        $past(rd_cmd_i inside {[3'h1:3'h4]})) else $error("bad read valid");
    guard_ext_a: assert property (rd_cmd_i == 3'h1 |=>
        rd_data_o == {{24{$past(ra[71])}}, $past(ra[71:64])})
        else $error("guard read not sign copy");
    high_rd_a: assert property (rd_cmd_i == 3'h2 |=>
        rd_data_o == $past(ra[63:32])) else $error("bad high read");
    mid_rd_a: assert property (rd_cmd_i == 3'h3 |=>
        rd_data_o == $past(ra[47:16])) else $error("bad middle read");
    low_rd_a: assert property (rd_cmd_i == 3'h4 |=>
        rd_data_o == $past(ra[31:0])) else $error("bad low read");
    prod_load_a: assert property (prod_we_i |=>
        accumulator_zero_o == $past(prod_data_i)) else $error("product not loaded");
    guard_wr_a: assert property (wr_cmd_i == 2'h1 && wr_sel_i |=>
        accumulator_one_o == {$past(wr_data_i[7:0]), $past(accumulator_one_o[63:0])})
        else $error("bad guard write");
    high_wr_a: assert property (wr_cmd_i == 2'h2 && !wr_sel_i
        && !prod_we_i |=> accumulator_zero_o == {$past(accumulator_zero_o[71:64]),
        $past(wr_data_i), $past(accumulator_zero_o[31:0])}) else $error("bad high write");
endmodule
bind dacc_pair dacc_chk u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_sel_i(wr_sel_i),
    .wr_cmd_i(wr_cmd_i),
    .wr_data_i(wr_data_i),
    .rd_sel_i(rd_sel_i),
    .rd_cmd_i(rd_cmd_i),
    .prod_we_i(prod_we_i),
    .prod_data_i(prod_data_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .accumulator_zero_o(accumulator_zero_o),
    .accumulator_one_o(accumulator_one_o)
);
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t value mismatch", $time); end end
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wr_sel_i = 1'b0, rd_sel_i = 1'b0;
    logic go = 1'b0, rd_valid_o, prod_we_i;
    dacc_pkg::dacc_wr_t wr_cmd_i = dacc_pkg::DACC_WR_NONE;
    dacc_pkg::dacc_rd_t rd_cmd_i = dacc_pkg::DACC_RD_NONE;
    logic [31:0] wr_data_i = 32'h0, ma = 32'h0, xs = 32'h2D, rd_data_o, erd;
    logic [71:0] prod_data_i, accumulator_zero_o, accumulator_one_o, m [2];
    int failures = 0, num_checks = 0;
    // 25 MHz core clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    dacc_mpy u_mpy (.go_i(go), .a_i(ma), .b_i(wr_data_i),
        .prod_we_o(prod_we_i), .prod_data_o(prod_data_i));
    dacc_pair uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_sel_i(wr_sel_i),
        .wr_cmd_i(wr_cmd_i),
        .wr_data_i(wr_data_i),
        .rd_sel_i(rd_sel_i),
        .rd_cmd_i(rd_cmd_i),
        .prod_we_i(prod_we_i),
        .prod_data_i(prod_data_i),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o),
        .accumulator_zero_o(accumulator_zero_o),
        .accumulator_one_o(accumulator_one_o)
    );
    function automatic logic [31:0] nxt(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // expected slice of the 96-bit view
    function automatic logic [31:0] slice(logic [71:0] a, logic [2:0] c);
        logic [95:0] w;
        w = {{24{a[71]}}, a};
        return c == 3'h1 ? w[95:64] : c == 3'h2 ? w[63:32] :
            c == 3'h3 ? w[47:16] : w[31:0];
    endfunction
    // slice write; guard keeps only the stored bits 71:64
    function automatic logic [71:0] wmod(logic [71:0] a, logic [1:0] c,
        logic [31:0] d);
        case (c)
            2'h1: a[71:64] = d[7:0];
            2'h2: a[63:32] = d;
            2'h3: a[31:0] = d;
            default: ;
        endcase
        return a;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // random traffic; the first cycles write junk above bit 71
    initial begin
        m[0] = 72'h0;
        m[1] = 72'h0;
        erd = 32'h0;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        `CHK({accumulator_zero_o, accumulator_one_o, rd_data_o, rd_valid_o}, 177'h0)
        for (int i = 0; i < 400; i++) begin
            xs = nxt(xs);
            wr_cmd_i = dacc_pkg::dacc_wr_t'(i < 8 ? 2'h1 : xs[1:0]);
            rd_cmd_i = dacc_pkg::dacc_rd_t'(xs[4:2]);
            wr_sel_i = xs[5];
            rd_sel_i = xs[6];
            go = xs[7] & xs[8];
            ma = nxt(xs);
            wr_data_i = (i < 8) ? 32'hFFFF_FF80 : ma ^ xs;
            @(negedge clk_i);
            if (rd_cmd_i inside {[3'h1:3'h4]}) begin
                erd = slice(m[rd_sel_i], rd_cmd_i);
            end
            `CHK(rd_valid_o, rd_cmd_i inside {[3'h1:3'h4]})
            `CHK(rd_data_o, erd)
            m[wr_sel_i] = wmod(m[wr_sel_i], wr_cmd_i, wr_data_i);
            if (go) m[0] = {40'h0, ma} * {40'h0, wr_data_i};
            `CHK(accumulator_zero_o, m[0])
            `CHK(accumulator_one_o, m[1])
        end
        // end-of-run reset clears both accumulators and the read port at once
        rst_i = 1'b1;
        wr_cmd_i = dacc_pkg::DACC_WR_NONE;
        rd_cmd_i = dacc_pkg::DACC_RD_NONE;
        go = 1'b0;
        @(negedge clk_i);
        rst_i = 1'b0;
        `CHK({accumulator_zero_o, accumulator_one_o, rd_data_o, rd_valid_o}, 177'h0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
